/* pkg/sbrms_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SBRMS_REGS_SVH
`define SBRMS_REGS_SVH
`define SBRMS_ADDR_DIVISOR 4'h0
`define SBRMS_ADDR_MODE 4'h1
`define SBRMS_ADDR_BIT_ORDER 4'h2
`define SBRMS_ADDR_HALT 4'h3
`define SBRMS_ADDR_STATUS 4'h4
`define SBRMS_ADDR_TX_DATA 4'h5
`define SBRMS_ADDR_RX_DATA 4'h6
`define SBRMS_DIVISOR_RST 8'hFF
`define SBRMS_MODE_RST 8'h00
`define SBRMS_MODE_CKS_LO 0
`define SBRMS_MODE_CKS_HI 1
`define SBRMS_MODE_SYNC 2
`define SBRMS_MODE_EXT 3
`define SBRMS_MODE_SEVEN 4
`define SBRMS_BIT_ORDER_RST 8'hF2
`define SBRMS_BIT_ORDER_FIXED 8'hF2
`define SBRMS_BIT_ORDER_RW 8'h0D
`define SBRMS_BO_DIR 3
`define SBRMS_BO_INV 2
`define SBRMS_BO_CARD 0
`define SBRMS_HALT_RST 16'h3FFF
`define SBRMS_HALT_CH1 6
`define SBRMS_HALT_CH0 5
`define SBRMS_ASYNC_DIV 6'h20
`define SBRMS_EXT_ASYNC_RATIO 4
`define SBRMS_EXT_SYNC_RATIO 6
`define SBRMS_OVERSAMPLE 5'h10
`endif

/* pkg/sbrms_pkg.sv */
// types shared by the bit-rate and module stop block
package sbrms_pkg;
  typedef enum logic [1:0] {
    sbrms_pre_div1 = 2'h0,
    sbrms_pre_div4 = 2'h1,
    sbrms_pre_div16 = 2'h2,
    sbrms_pre_div64 = 2'h3
  } sbrms_prescale_t;
  typedef enum logic [1:0] {
    sbrms_idle = 2'h0,
    sbrms_load = 2'h1,
    sbrms_shift = 2'h3
  } sbrms_shift_state_t;
endpackage : sbrms_pkg

/* rtl/sbrms_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbrms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  // handshake terms
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : sbrms_fifo
`default_nettype wire

/* rtl/sbrms_core.sv */
// bit-rate generator, bit-order control and module stop for one serial channel
// ***********************************************************************
// Notes on behaviour
// (R1) divisor = f/(64*2^(2n-1)*B)-1 async, f/(8*2^(2n-1)*B)-1 sync
// (R2) divisor is eight bits, any value 0..255 accepted
// (R3) prescale code 00/01/10/11 selects clock /1, /4, /16, /64
// (R4) sync mode, divisor 0 at /1: continuous transfer not sustained
// (R5) async internal fastest rate is clock/32 at code 0 divisor 0
// (R6) async external clock at most clock/4; bit rate is its /16
// (R7) sync external serial clock at most clock/6
// (R8) async error% = (f/((N+1)*B*64*2^(2n-1)) - 1) * 100
// (R9) bit-order bits 7..4 and 1 reserved, unwritable, read one
// (R10) bit-order register resets on reset, standby and module stop
// (R11) direction 0 shifts LSB first, 1 shifts MSB first, both ways; only the transmit shifter here, no receive path
// (R12) bit order applies to 8-bit data, not 7-bit async frames
// (R13) software keeps inversion and card select zero for plain serial use
// (R14) halt bit one stops the channel after the current bus cycle
// (R15) stopped channel ignores writes and returns no valid read data
// (R16) halt register resets on reset and hardware standby only
// (R17) bit 6 halts channel one, bit 5 channel zero, both default one
// (R18) async external clock runs at sixteen times bit rate, generator bypassed
// (R19) counter on prescaled clock reloads from divisor at zero, ticks
// ***********************************************************************
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sbrms_regs.svh"
module sbrms_core #(
  parameter int CHANNEL = 0,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic ext_clk_in,
  output logic serial_clk_out,
  output logic serial_clk_oe_n,
  output logic serial_tx,
  output logic bit_tick,
  output logic channel_halted
);
  // ***********************************************************************
  // registers
  // ***********************************************************************
  logic [7:0] bit_rate_divisor;
  logic [7:0] mode_ctrl;
  logic [7:0] serial_bit_order_control;
  logic [15:0] peripheral_halt_control;
  logic halted;
  logic stop_req;
  logic acc_ok;
  logic bo_clear;
  logic [15:0] rd_mux;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic tx_push;
  sbrms_pkg::sbrms_prescale_t prescale;
  logic sync_mode;
  logic ext_mode;
  logic seven_bit;

  assign prescale = sbrms_pkg::sbrms_prescale_t'({mode_ctrl[`SBRMS_MODE_CKS_HI], mode_ctrl[`SBRMS_MODE_CKS_LO]});
  assign sync_mode = mode_ctrl[`SBRMS_MODE_SYNC];
  assign ext_mode = mode_ctrl[`SBRMS_MODE_EXT];
  assign seven_bit = mode_ctrl[`SBRMS_MODE_SEVEN] && !sync_mode;
  // halt bit of this channel
  assign stop_req = (CHANNEL == 1) ? peripheral_halt_control[`SBRMS_HALT_CH1]
                                   : peripheral_halt_control[`SBRMS_HALT_CH0]; // R17
  assign acc_ok = !halted; // R15
  assign bo_clear = halted || sw_standby || hw_standby;
  assign tx_push = reg_wr && acc_ok && (reg_addr == `SBRMS_ADDR_TX_DATA) && fifo_in_ready;
  assign channel_halted = halted;

  // halt register: keeps contents through software standby
  always_ff @(posedge sys_clk) begin
    if (!rstn || hw_standby) begin
      peripheral_halt_control <= `SBRMS_HALT_RST; // R16
    end else if (reg_wr && reg_addr == `SBRMS_ADDR_HALT) begin
      peripheral_halt_control <= reg_wdata;
    end
  end

  // stop takes effect one cycle later, after the bus cycle completes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      halted <= 1'b1;
    end else begin
      halted <= stop_req; // R14
    end
  end

  // divisor and mode
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      bit_rate_divisor <= `SBRMS_DIVISOR_RST;
      mode_ctrl <= `SBRMS_MODE_RST;
    end else if (reg_wr && acc_ok) begin // R15
      if (reg_addr == `SBRMS_ADDR_DIVISOR) begin
        bit_rate_divisor <= reg_wdata[7:0]; // R2
      end
      if (reg_addr == `SBRMS_ADDR_MODE) begin
        mode_ctrl <= reg_wdata[7:0];
      end
    end
  end

  // bit-order register with fixed reserved ones
  always_ff @(posedge sys_clk) begin
    if (!rstn || bo_clear) begin
      serial_bit_order_control <= `SBRMS_BIT_ORDER_RST; // R10
    end else if (reg_wr && acc_ok && reg_addr == `SBRMS_ADDR_BIT_ORDER) begin
      serial_bit_order_control <= (reg_wdata[7:0] & `SBRMS_BIT_ORDER_RW) | `SBRMS_BIT_ORDER_FIXED; // R9
    end
  end

  // read mux
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `SBRMS_ADDR_DIVISOR: rd_mux = {8'h00, bit_rate_divisor};
      `SBRMS_ADDR_MODE: rd_mux = {8'h00, mode_ctrl};
      `SBRMS_ADDR_BIT_ORDER: rd_mux = {8'h00, serial_bit_order_control};
      `SBRMS_ADDR_HALT: rd_mux = peripheral_halt_control;
      `SBRMS_ADDR_STATUS: rd_mux = {12'h000, fifo_out_valid, !fifo_in_ready, bit_tick, halted};
      default: rd_mux = 16'h0000;
    endcase
  end

  // read data one cycle after strobe; stopped channel returns zero except halt reg
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= (acc_ok || reg_addr == `SBRMS_ADDR_HALT) ? rd_mux : 16'h0000; // R15
    end
  end

  // ***********************************************************************
  // prescaler and divisor counter
  // ***********************************************************************
  logic [5:0] pre_cnt;
  logic pre_tick;
  logic [7:0] div_cnt;
  logic gen_tick;

  // free prescale counter; tick at /1, /4, /16, /64
  always_ff @(posedge sys_clk) begin
    if (!rstn || halted) begin
      pre_cnt <= 6'h00;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end
  always_comb begin
    case (prescale)
      sbrms_pkg::sbrms_pre_div1: pre_tick = 1'b1; // R3
      sbrms_pkg::sbrms_pre_div4: pre_tick = (pre_cnt[1:0] == 2'h3);
      sbrms_pkg::sbrms_pre_div16: pre_tick = (pre_cnt[3:0] == 4'hF);
      sbrms_pkg::sbrms_pre_div64: pre_tick = (pre_cnt == 6'h3F);
      default: pre_tick = 1'b0;
    endcase
  end

  // reload counter: N+1 prescaled ticks per generator tick
  always_ff @(posedge sys_clk) begin
    if (!rstn || halted) begin
      div_cnt <= 8'h00;
      gen_tick <= 1'b0;
    end else begin
      gen_tick <= 1'b0;
      if (pre_tick) begin
        if (div_cnt == 8'h00) begin
          div_cnt <= bit_rate_divisor; // R19
          gen_tick <= 1'b1; // R1
        end else begin
          div_cnt <= div_cnt - 8'h01;
        end
      end
    end
  end

  // ***********************************************************************
  // external clock sampling
  // ***********************************************************************
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_rise;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  // edge detection on the synchronised copy only; limits clock/4 async, clock/6 sync
  assign ext_rise = ext_s2 && !ext_s3; // R6 R7

  // ***********************************************************************
  // bit clock: half-bit toggles sync, 16x oversampling async
  // ***********************************************************************
  logic [3:0] os_cnt;
  logic [2:0] half_cnt;
  logic clk_phase;
  logic base_tick;
  // internal async: two gen_ticks per oversample step, 16 steps per bit -> clock/32 at best
  // external async: input at 16x bit rate bypasses generator
  assign base_tick = ext_mode ? ext_rise : gen_tick; // R18

  always_ff @(posedge sys_clk) begin
    if (!rstn || halted) begin
      os_cnt <= 4'h0;
      half_cnt <= 3'h0;
      clk_phase <= 1'b1;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (sync_mode) begin
        // sync: two generator ticks per half bit, so a bit is 4*P*(N+1); external edge is a whole bit
        if (ext_mode) begin
          bit_tick <= ext_rise; // R7
        end else if (gen_tick) begin
          if (half_cnt[0]) begin
            half_cnt <= 3'h0;
            clk_phase <= !clk_phase;
            bit_tick <= clk_phase; // R1 R4
          end else begin
            half_cnt <= half_cnt + 3'h1;
          end
        end
      end else if (base_tick) begin
        // async: sixteen base ticks per bit; internal also halves first
        if (!ext_mode && half_cnt[0] == 1'b0) begin
          half_cnt <= half_cnt + 3'h1;
        end else begin
          half_cnt <= 3'h0;
          os_cnt <= os_cnt + 4'h1;
          if (os_cnt == 4'hF) begin
            bit_tick <= 1'b1; // R5 R6
          end
          if (os_cnt[2:0] == 3'h7) begin
            clk_phase <= !clk_phase;
          end
        end
      end
    end
  end

  // clock pin drives out only when clock is internal
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      serial_clk_out <= 1'b1;
      serial_clk_oe_n <= 1'b1;
    end else begin
      serial_clk_out <= clk_phase;
      serial_clk_oe_n <= ext_mode || halted; // R4
    end
  end

  // ***********************************************************************
  // transmit buffer and shifter
  // ***********************************************************************
  sbrms_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(tx_push),
    .in_ready(fifo_in_ready),
    .in_data(reg_wdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  sbrms_pkg::sbrms_shift_state_t state;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic msb_first;
  // MSB first only for 8-bit data
  assign msb_first = serial_bit_order_control[`SBRMS_BO_DIR] && !seven_bit; // R12
  assign fifo_out_ready = (state == sbrms_pkg::sbrms_idle) && !halted;

  always_ff @(posedge sys_clk) begin
    if (!rstn || halted) begin
      state <= sbrms_pkg::sbrms_idle;
      shreg <= 8'h00;
      bits_left <= 4'h0;
      serial_tx <= 1'b1;
    end else begin
      case (state)
        sbrms_pkg::sbrms_idle: begin
          serial_tx <= 1'b1;
          if (fifo_out_valid) begin
            shreg <= fifo_out_data;
            bits_left <= seven_bit ? 4'h7 : 4'h8;
            state <= sbrms_pkg::sbrms_load;
          end
        end
        sbrms_pkg::sbrms_load: begin
          if (bit_tick) begin
            state <= sbrms_pkg::sbrms_shift;
          end
        end
        sbrms_pkg::sbrms_shift: begin
          if (bit_tick) begin
            if (bits_left == 4'h0) begin
              serial_tx <= 1'b1;
              state <= sbrms_pkg::sbrms_idle;
            end else begin
              // inversion and card select bits are left to software
              serial_tx <= msb_first ? shreg[7] : shreg[0]; // R11 R13
              shreg <= msb_first ? {shreg[6:0], 1'b0} : {1'b0, shreg[7:1]}; // R11
              bits_left <= bits_left - 4'h1;
            end
          end
        end
        default: state <= sbrms_pkg::sbrms_idle;
      endcase
    end
  end
  // error figure (R8) is a software calculation over the divisor; no logic needed
endmodule : sbrms_core
`default_nettype wire

/* test/sbrms_core_checker.sv */
// port-level checker for the bit-rate and halt block
`timescale 1ns/1ps
`default_nettype none
module sbrms_core_checker #(
  parameter int CHANNEL = 0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic ext_clk_in,
  input wire logic serial_clk_out,
  input wire logic serial_clk_oe_n,
  input wire logic serial_tx,
  input wire logic bit_tick,
  input wire logic channel_halted
);
  // ********
  // port relations
  // ********
  localparam int HB = (CHANNEL == 1) ? 6 : 5;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reset_values_a: assert property (disable iff (1'b0) !rstn |=>
    reg_rdata == 16'h0000 && serial_tx && channel_halted && !bit_tick && serial_clk_oe_n)
    else $error("outputs wrong after reset");
  halt_follows_a: assert property (reg_wr && reg_addr == 4'h3 |->
    ##2 channel_halted == $past(reg_wdata[HB], 2)) else $error("halt state does not follow halt bit");
  hw_standby_halt_a: assert property (hw_standby |-> ##2 channel_halted)
    else $error("hardware standby did not stop channel");
  halted_read_zero_a: assert property (reg_rd && reg_addr != 4'h3 && channel_halted &&
    !$past(reg_wr) |=> reg_rdata == 16'h0000) else $error("stopped channel returned data");
  halted_no_tick_a: assert property (channel_halted [*3] |-> !bit_tick)
    else $error("tick while stopped");
  halted_oe_off_a: assert property ($past(channel_halted) && channel_halted |-> serial_clk_oe_n)
    else $error("clock pin driven while stopped");
  tick_single_a: assert property (bit_tick |=> !bit_tick)
    else $error("tick longer than one cycle");
  read_hold_a: assert property ($past(rstn) && !$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  bo_fixed_ones_a: assert property (reg_rd && reg_addr == 4'h2 && !channel_halted |=>
    reg_rdata[7:4] == 4'hF && reg_rdata[1]) else $error("reserved bit-order bits not one");
endmodule : sbrms_core_checker
`default_nettype wire
bind sbrms_core sbrms_core_checker #(.CHANNEL(CHANNEL)) chk_i (.sys_clk(sys_clk), .rstn(rstn),
  .hw_standby(hw_standby), .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
  .serial_clk_out(serial_clk_out), .serial_clk_oe_n(serial_clk_oe_n), .serial_tx(serial_tx),
  .bit_tick(bit_tick), .channel_halted(channel_halted));

/* test/sbrms_remote.sv */
// far-end model: source of the external serial clock
`timescale 1ns/1ps
`default_nettype none
module sbrms_remote (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic ext_clk
);
  // ********
  // external clock source
  // ********
  logic [7:0] cnt;
  initial ext_clk = 1'b0;
  // toggles every half cycles while running, rests low between uses
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt <= 8'h00;
      ext_clk <= 1'b0;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      ext_clk <= ~ext_clk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule : sbrms_remote
`default_nettype wire

/* test/tb_sbrms_core.sv */
// self-checking bench for the bit-rate, bit-order and halt block
`timescale 1ns/1ps
`default_nettype none
`include "sbrms_regs.svh"
module tb_sbrms_core;
  // ********
  // signals, design and far end
  // ********
  logic sys_clk, rstn, hw_standby, sw_standby, reg_wr, reg_rd, run, ext_clk_in;
  logic serial_clk_out, serial_clk_oe_n, serial_tx, bit_tick, channel_halted;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v, d;
  logic [7:0] half;
  int fails, check_count, seed, n, i, k;
  sbrms_core #(.CHANNEL(0), .FIFO_DEPTH(8)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
    .serial_clk_out(serial_clk_out), .serial_clk_oe_n(serial_clk_oe_n), .serial_tx(serial_tx),
    .bit_tick(bit_tick), .channel_halted(channel_halted));
  sbrms_remote far_end (.sys_clk(sys_clk), .run(run), .half(half), .ext_clk(ext_clk_in));
  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task close_out;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task stby(input logic hw);
    @(posedge sys_clk);
    hw_standby <= hw;
    sw_standby <= !hw;
    @(posedge sys_clk);
    hw_standby <= 1'b0;
    sw_standby <= 1'b0;
  endtask : stby
  // cycles up to the next tick, left in n
  task tick;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (bit_tick !== 1'b1 && n < 9000);
    if (n >= 9000) fails++;
  endtask : tick
  function automatic logic [15:0] per(input logic sync, input logic [1:0] c, input logic [7:0] dv);
    per = 16'((sync ? 4 : 32) * (1 << (2 * c)) * (dv + 1));
  endfunction : per
  // bound on the whole run, several times the expected length
  initial begin
    #200000;
    fails++;
    close_out;
  end
  // ********
  // main sequence
  // ********
  initial begin
    seed = 32'h9b4a00d0;
    fails = 0;
    check_count = 0;
    {rstn, hw_standby, sw_standby, reg_wr, reg_rd, run} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    half = 8'h02;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    chk({15'h0, channel_halted}, 16'h0001);
    rd(`SBRMS_ADDR_HALT);
    chk(v, `SBRMS_HALT_RST);
    wr(`SBRMS_ADDR_DIVISOR, 16'h0012);
    rd(`SBRMS_ADDR_BIT_ORDER);
    chk(v, 16'h0000);
    wr(`SBRMS_ADDR_HALT, 16'h3FDF);
    rd(`SBRMS_ADDR_DIVISOR);
    chk(v, {8'h00, `SBRMS_DIVISOR_RST});
    // divisor and bit-order traffic, corners first, then random
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h00FF : 16'($random(seed)) & 16'h00FF;
      wr(`SBRMS_ADDR_DIVISOR, d);
      rd(`SBRMS_ADDR_DIVISOR);
      chk(v, d);
      d = 16'($random(seed)) & 16'hFFFA;
      wr(`SBRMS_ADDR_BIT_ORDER, d);
      rd(`SBRMS_ADDR_BIT_ORDER);
      chk(v, {8'h00, 8'hF2 | (d[7:0] & 8'h08)});
    end
    // bit order back to initial on software standby and module stop
    stby(1'b0);
    rd(`SBRMS_ADDR_BIT_ORDER);
    chk(v, 16'h00F2);
    rd(`SBRMS_ADDR_HALT);
    chk(v, 16'h3FDF);
    wr(`SBRMS_ADDR_BIT_ORDER, 16'h0008);
    wr(`SBRMS_ADDR_HALT, 16'h3FFF);
    wr(`SBRMS_ADDR_HALT, 16'h3FDF);
    rd(`SBRMS_ADDR_BIT_ORDER);
    chk(v, 16'h00F2);
    stby(1'b1);
    rd(`SBRMS_ADDR_HALT);
    chk(v, 16'h3FFF);
    wr(`SBRMS_ADDR_HALT, 16'h3FDF);
    // internal generator: sync over every code, async at code 0 divisor 0 and at code 1 with a divisor of 0..3
    for (i = 0; i < 6; i++) begin
      d = (i % 4 == 0) ? 16'h0000 : 16'($random(seed)) & 16'h0003;
      wr(`SBRMS_ADDR_DIVISOR, d);
      wr(`SBRMS_ADDR_MODE, {13'h0000, i < 4, 2'(i % 4)});
      repeat (3) tick;
      chk(16'(n), per(i < 4, 2'(i % 4), d[7:0]));
      chk({14'h0000, serial_clk_out | (i >= 4), serial_clk_oe_n}, 16'h0002);
    end
    // external clock at its limits: async /16, sync one bit per edge
    run <= 1'b1;
    wr(`SBRMS_ADDR_MODE, 16'h0008);
    repeat (3) tick;
    chk(16'(n), 16'd64);
    half <= 8'h03;
    wr(`SBRMS_ADDR_MODE, 16'h000C);
    repeat (3) tick;
    chk(16'(n), 16'd6);
    chk({15'h0000, serial_clk_oe_n}, 16'h0001);
    run <= 1'b0;
    // fill the transmit buffer against a very slow line, then drain it
    wr(`SBRMS_ADDR_DIVISOR, 16'h00FF);
    wr(`SBRMS_ADDR_MODE, 16'h0007);
    repeat (10) wr(`SBRMS_ADDR_TX_DATA, 16'($random(seed)) & 16'h00FF);
    rd(`SBRMS_ADDR_STATUS);
    chk({15'h0000, v[2]}, 16'h0001);
    wr(`SBRMS_ADDR_DIVISOR, 16'h0000);
    wr(`SBRMS_ADDR_MODE, 16'h0004);
    k = 0;
    do begin
      rd(`SBRMS_ADDR_STATUS);
      k++;
    end while (v[3] !== 1'b0 && k < 600);
    chk({14'h0000, v[3:2]}, 16'h0000);
    // bit order on the line: lsb first, msb first, 7-bit async ignores it
    for (i = 0; i < 3; i++) begin
      repeat (12) tick;
      wr(`SBRMS_ADDR_MODE, i < 2 ? 16'h0004 : 16'h0010);
      wr(`SBRMS_ADDR_BIT_ORDER, i == 0 ? 16'h0000 : 16'h0008);
      wr(`SBRMS_ADDR_TX_DATA, 16'h00FE);
      k = 0;
      while (serial_tx !== 1'b0 && k < 16) begin
        tick;
        k++;
      end
      chk(16'(i == 1 ? (k > 5 && k < 16) : (k < 4)), 16'h0001);
    end
    close_out;
  end
endmodule : tb_sbrms_core
`default_nettype wire
